// >>> rtl/numc_params.svh
`ifndef NUMC_PARAMS_SVH
`define NUMC_PARAMS_SVH
// ==========================================
// Status word fields
`define SW_BUSY 15
`define SW_C3 14
`define SW_TOP_HI 13
`define SW_TOP_LO 11
`define SW_CC_HI 10
`define SW_CC_LO 8
`define SW_IR 7
`define SW_EXC_HI 5
// ==========================================
// Control word fields and values
`define CW_MSK_HI 5
`define CW_IEM 7
`define CW_PC_HI 9
`define CW_PC_LO 8
`define CW_WMASK 16'h1FBF
`define CW_RST 16'h00BF
`define PC_24 2'h0
`define PC_53 2'h2
`define PC_64 2'h3
`define SIG_24 7'h18
`define SIG_53 7'h35
`define SIG_64 7'h40
// ==========================================
// Tag codes and reset
`define TW_RST 16'hFFFF
`define TAG_EMPTY 2'h3
// ==========================================
// Instruction stream
`define ESC_PREFIX 5'h1B
`define QS_FIRST 2'h1
`define QS_EMPTY 2'h2
`define QS_NEXT 2'h3
`define SYNC_W 11
`endif

// >>> rtl/numc_pkg.sv
// ==========================================
// Shared types
package numc_pkg;
    // Executed operation kinds
    typedef enum logic [3:0] {
        OP_PUSH, OP_POP, OP_WRITE, OP_READ, OP_CMP, OP_CLEX,
        OP_LDCW, OP_LDTW, OP_DISI, OP_DECSTP, OP_INCSTP
    } numc_op_t;
    // Execution phase
    typedef enum logic {PH_IDLE, PH_EXEC} numc_state_t;
    // Extended precision word
    typedef logic [79:0] numc_ext_t;
endpackage : numc_pkg

// >>> rtl/numc_trk_if.sv
`timescale 1ns/1ps
// ==========================================
// Tracker to core signals
interface numc_trk_if;
    logic [1:0] qs_code; // Stable queue status
    logic [6:0] bus_status; // Stable bus status
    logic first_byte; // First opcode byte pulse
    logic next_byte; // Later byte pulse
    logic flush; // Queue emptied pulse
    logic switch_on; // Board switch stable
    logic parity_err; // Parity error stable
    modport trk (output qs_code, bus_status, first_byte, next_byte,
        flush, switch_on, parity_err);
    modport core (input qs_code, bus_status, first_byte, next_byte,
        flush, switch_on, parity_err);
endinterface : numc_trk_if

// >>> rtl/numc_tracker.sv
`timescale 1ns/1ps
`include "numc_params.svh"
// ==========================================
// Pin synchroniser and queue status decode
module numc_tracker (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Raw pins: parity, switch, bus status, queue status
    input wire logic [10:0] pins,
    // Decoded stream events
    numc_trk_if.trk trk
);
    import numc_pkg::*;
    // Tracker state
    typedef struct packed {
        logic [10:0] s1; // First stage
        logic [10:0] s2; // Second stage
        logic [10:0] s3; // Third stage
        logic [10:0] stab; // Accepted level
        logic first;
        logic next;
        logic flush;
    } numc_trk_t;
    numc_trk_t st, n;
    // Next state
    always_comb begin
        n = st;
        n.s1 = pins;
        n.s2 = st.s1;
        n.s3 = st.s2;
        // Change counts once stages two and three agree
        n.stab = (st.s2 & st.s3) | (st.stab & (st.s2 ^ st.s3));
        // Queue code edges become byte events
        n.first = 1'b0;
        n.next = 1'b0;
        n.flush = 1'b0;
        if (n.stab[1:0] != st.stab[1:0]) begin
            n.first = n.stab[1:0] == `QS_FIRST;
            n.next = n.stab[1:0] == `QS_NEXT;
            n.flush = n.stab[1:0] == `QS_EMPTY;
        end
        if (sys_rst) begin
            n = '0;
        end
    end
    // State register
    always_ff @(posedge clk) begin
        st <= n;
    end
    assign trk.qs_code = st.stab[1:0];
    assign trk.bus_status = st.stab[8:2];
    assign trk.switch_on = st.stab[9];
    assign trk.parity_err = st.stab[10];
    assign trk.first_byte = st.first;
    assign trk.next_byte = st.next;
    assign trk.flush = st.flush;
    // Never a first and a next byte event at once
    single_event_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(st.first && st.next)) else $error("two byte events at once");
endmodule : numc_tracker

// >>> rtl/numc_core.sv
`timescale 1ns/1ps
`include "numc_params.svh"
// ==========================================
// Coprocessor programming model and host coupling
module numc_core (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host shared status pins
    input wire logic queue_status_low,
    input wire logic queue_status_high,
    input wire logic [6:0] bus_status_lines,
    // Board pins
    input wire logic board_switch_on,
    input wire logic parity_error,
    // Host interrupt mask register write
    input wire logic nmi_mask_wr,
    input wire logic nmi_mask_val,
    // Instruction execute port
    input wire logic cmd_valid,
    input wire numc_pkg::numc_op_t cmd_op,
    input wire logic [2:0] cmd_index,
    input wire numc_pkg::numc_ext_t cmd_data,
    input wire logic [5:0] cmd_exc,
    input wire logic [3:0] cmd_cc,
    input wire logic [1:0] cmd_tag,
    input wire logic [7:0] cmd_cycles,
    input wire logic [15:0] cmd_opcode,
    input wire logic [19:0] cmd_ins_addr,
    input wire logic [19:0] cmd_opnd_addr,
    // Handshake and interrupt outputs
    output logic cmd_ready,
    output logic busy,
    output logic cop_irq,
    output logic nmi_out,
    output logic nmi_mask,
    // Register views
    output logic [15:0] status_word,
    output logic [15:0] control_word,
    output logic [15:0] tag_word,
    output logic [6:0] sig_bits,
    output numc_pkg::numc_ext_t rd_data,
    output logic rd_valid,
    output logic [19:0] operand_address_pointer,
    output logic [10:0] captured_opcode,
    output logic [19:0] instruction_address_pointer,
    // Stream tracking views
    output logic [7:0] stream_bytes,
    output logic [6:0] bus_status_seen
);
    import numc_pkg::*;
    // ==========================================
    // State
    typedef struct packed {
        numc_state_t state; // Idle or executing
        logic [7:0] cnt; // Cycles left
        numc_op_t op; // Latched operation
        logic [2:0] idx; // Latched operand index
        numc_ext_t data; // Latched value
        logic [5:0] exc; // Latched exceptions
        logic [3:0] cc; // Latched condition code
        logic [1:0] tag; // Latched tag
        logic [15:0] sw; // Status word
        logic [15:0] cw; // Control word
        logic [15:0] tw; // Tag word
        logic [7:0][79:0] stk; // Register stack
        logic nmi_mask; // Host interrupt mask
        logic nmi; // Combined NMI
        logic irq; // Gated coprocessor request
        logic busy; // Busy pin
        logic ready; // Accepting work
        logic [6:0] sig; // Significand width
        numc_ext_t rd; // Read value
        logic rd_v; // Read strobe
        logic [19:0] opnd_ptr; // Operand address
        logic [10:0] opc; // Opcode low bits
        logic [19:0] ins_ptr; // Instruction address
        logic [7:0] bytes; // Bytes since first opcode byte, zero after flush
        logic [6:0] bus_seen; // Bus status copy
    } numc_core_t;
    numc_core_t st, n;
    // Tracker link
    numc_trk_if trk ();
    // Derived helpers
    logic accept; // Instruction taken
    logic clex_now; // No-wait clear taken
    logic done; // Last execution cycle
    logic [2:0] top_cur; // Current stack top
    logic [2:0] top_dn; // Top after push
    logic [2:0] top_up; // Top after pop
    logic [2:0] sel; // Top-relative register
    // ==========================================
    // Pin tracking
    numc_tracker u_trk (
        .clk(clk),
        .sys_rst(sys_rst),
        .pins({parity_error, board_switch_on, bus_status_lines,
            queue_status_high, queue_status_low}),
        .trk(trk)
    );
    // ==========================================
    // Acceptance and stack pointer arithmetic
    assign accept = cmd_valid && (cmd_opcode[15:11] == `ESC_PREFIX)
        && (st.state == PH_IDLE || cmd_op == OP_CLEX);
    assign clex_now = accept && cmd_op == OP_CLEX;
    assign done = st.state == PH_EXEC && st.cnt == 8'h01 && !clex_now;
    assign top_cur = st.sw[`SW_TOP_HI:`SW_TOP_LO];
    assign top_dn = top_cur - 3'h1;
    assign top_up = top_cur + 3'h1;
    assign sel = top_cur + st.idx;
    // ==========================================
    // Next state
    always_comb begin
        n = st;
        n.rd_v = 1'b0;
        // Host interrupt mask register
        if (nmi_mask_wr) begin
            n.nmi_mask = nmi_mask_val;
        end
        // Fetched byte tracking
        if (trk.flush) begin
            n.bytes = 8'h00;
        end else if (trk.first_byte) begin
            n.bytes = 8'h01;
        end else if (trk.next_byte) begin
            n.bytes = st.bytes + 8'h01;
        end
        n.bus_seen = trk.bus_status;
        if (accept) begin
            // Pointer capture on every accepted instruction
            n.ins_ptr = cmd_ins_addr;
            n.opnd_ptr = cmd_opnd_addr;
            n.opc = cmd_opcode[10:0];
            if (clex_now) begin
                // Clear flags, request and busy; abort work
                n.sw[`SW_EXC_HI:0] = 6'h00;
                n.sw[`SW_BUSY] = 1'b0;
                n.state = PH_IDLE;
            end else begin
                // Latch and start executing
                n.op = cmd_op;
                n.idx = cmd_index;
                n.data = cmd_data;
                n.exc = cmd_exc;
                n.cc = cmd_cc;
                n.tag = cmd_tag;
                n.cnt = (cmd_cycles == 8'h00) ? 8'h01 : cmd_cycles;
                n.sw[`SW_BUSY] = 1'b1;
                n.state = PH_EXEC;
            end
        end else if (st.state == PH_EXEC && !done) begin
            // Count down execution time
            n.cnt = st.cnt - 8'h01;
        end else if (done) begin
            // Finish: post exceptions, leave busy
            n.sw[`SW_EXC_HI:0] = st.sw[`SW_EXC_HI:0] | st.exc;
            n.sw[`SW_BUSY] = 1'b0;
            n.state = PH_IDLE;
            unique case (st.op)
                OP_PUSH: begin
                    // Decrement top, then write new top
                    n.sw[`SW_TOP_HI:`SW_TOP_LO] = top_dn;
                    n.stk[top_dn] = st.data;
                    n.tw[{top_dn, 1'b0} +: 2] = st.tag;
                end
                OP_POP: begin
                    // Read top, mark empty, then increment
                    n.rd = st.stk[top_cur];
                    n.rd_v = 1'b1;
                    n.tw[{top_cur, 1'b0} +: 2] = `TAG_EMPTY;
                    n.sw[`SW_TOP_HI:`SW_TOP_LO] = top_up;
                end
                OP_WRITE: begin
                    // Result into top-relative register
                    n.stk[sel] = st.data;
                    n.tw[{sel, 1'b0} +: 2] = st.tag;
                    n.sw[`SW_C3] = st.cc[3];
                    n.sw[`SW_CC_HI:`SW_CC_LO] = st.cc[2:0];
                end
                OP_READ: begin
                    // Read top-relative register
                    n.rd = st.stk[sel];
                    n.rd_v = 1'b1;
                end
                OP_CMP: begin
                    // Comparison outcome only
                    n.sw[`SW_C3] = st.cc[3];
                    n.sw[`SW_CC_HI:`SW_CC_LO] = st.cc[2:0];
                end
                OP_CLEX: begin
                    // Never latched; clear acts at acceptance
                    n.sw[`SW_BUSY] = 1'b0;
                end
                OP_LDCW: begin
                    // Reserved control bits stay zero
                    n.cw = st.data[15:0] & `CW_WMASK;
                end
                OP_LDTW: begin
                    n.tw = st.data[15:0];
                end
                OP_DISI: begin
                    n.cw[`CW_IEM] = 1'b1;
                end
                OP_DECSTP: begin
                    n.sw[`SW_TOP_HI:`SW_TOP_LO] = top_dn;
                end
                OP_INCSTP: begin
                    n.sw[`SW_TOP_HI:`SW_TOP_LO] = top_up;
                end
            endcase
        end
        // Request from unmasked flags
        n.sw[`SW_IR] = |(n.sw[`SW_EXC_HI:0]
            & ~n.cw[`CW_MSK_HI:0]);
        n.sw[6] = 1'b0;
        // Request reaches host only with enable clear
        n.irq = n.sw[`SW_IR] & ~n.cw[`CW_IEM];
        // Switch and mask register gate, parity joins
        n.nmi = n.nmi_mask
            & ((n.irq & ~trk.switch_on) | trk.parity_err);
        n.busy = n.sw[`SW_BUSY];
        n.ready = n.state == PH_IDLE;
        // Significand width from precision field
        unique case (n.cw[`CW_PC_HI:`CW_PC_LO])
            `PC_24: n.sig = `SIG_24;
            `PC_53: n.sig = `SIG_53;
            `PC_64: n.sig = `SIG_64;
            default: n.sig = 7'h00;
        endcase
        // Synchronous reset to constants
        if (sys_rst) begin
            n = '0;
            n.cw = `CW_RST;
            n.tw = `TW_RST;
            n.ready = 1'b1;
            n.sig = `SIG_24;
            n.nmi_mask = 1'b0;
        end
    end
    // State register
    always_ff @(posedge clk) begin
        st <= n;
    end
    // ==========================================
    // Outputs
    assign cmd_ready = st.ready;
    assign busy = st.busy;
    assign cop_irq = st.irq;
    assign nmi_out = st.nmi;
    assign nmi_mask = st.nmi_mask;
    assign status_word = st.sw;
    assign control_word = st.cw;
    assign tag_word = st.tw;
    assign sig_bits = st.sig;
    assign rd_data = st.rd;
    assign rd_valid = st.rd_v;
    assign operand_address_pointer = st.opnd_ptr;
    assign captured_opcode = st.opc;
    assign instruction_address_pointer = st.ins_ptr;
    assign stream_bytes = st.bytes;
    assign bus_status_seen = st.bus_seen;
    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    busy_pin_match_a: assert property (
        busy == status_word[`SW_BUSY]) else $error("busy pin mismatch");
    busy_on_start_a: assert property (
        accept && !clex_now |=> busy [*1] ##0 !cmd_ready)
        else $error("busy not raised");
    push_top_a: assert property (
        done && st.op == OP_PUSH |=> top_cur == $past(top_cur) - 3'h1
        && st.stk[top_cur] == $past(st.data)) else $error("push wrong");
    pop_top_a: assert property (
        done && st.op == OP_POP |=> rd_valid
        && top_cur == $past(top_cur) + 3'h1) else $error("pop wrong");
    req_flag_a: assert property (
        status_word[`SW_IR] == |(status_word[5:0] & ~control_word[5:0]))
        else $error("request flag wrong");
    nmi_block_a: assert property (
        (!nmi_mask || control_word[`CW_IEM]) && !$past(trk.parity_err)
        |-> !nmi_out) else $error("nmi not blocked");
    clex_clear_a: assert property (
        clex_now |=> status_word[`SW_EXC_HI:0] == 6'h00
        && !status_word[`SW_IR] && !busy) else $error("clear incomplete");
    ptr_capture_a: assert property (
        accept |=> instruction_address_pointer == $past(cmd_ins_addr)
        && captured_opcode == $past(cmd_opcode[10:0]))
        else $error("pointer not captured");
    mask_reset_a: assert property (@(posedge clk)
        $fell(sys_rst) |-> !nmi_mask && !nmi_out) else $error("mask set");
endmodule : numc_core

// >>> rtl/numc_tracker_unused_guard.sv
`timescale 1ns/1ps

// >>> dv/numc_host_model.sv
`timescale 1ns/1ps
`include "numc_params.svh"
// ==========================================
// Host side: queue status and bus status
module numc_host_model (
    // Clock
    input wire logic clk,
    // Shared status lines
    output logic qs_low,
    output logic qs_high,
    output logic [6:0] bus_status
);
    // Idle code between fetches
    initial begin
        {qs_high, qs_low} = 2'h0;
        bus_status = 7'h7F;
    end
    // Hold a code long enough to pass the synchroniser
    task automatic put(input logic [1:0] q);
        {qs_high, qs_low} = q;
        repeat (4) @(posedge clk);
        #1;
    endtask : put
    // Fetch n bytes of one instruction
    task automatic fetch(input int n, input logic [6:0] bs);
        bus_status = bs;
        put(`QS_FIRST);
        for (int i = 1; i < n; i++) begin
            put(2'h0);
            put(`QS_NEXT);
        end
        put(2'h0);
    endtask : fetch
    // Empty the queue
    task automatic flush;
        put(`QS_EMPTY);
        put(2'h0);
    endtask : flush
endmodule : numc_host_model

// >>> dv/numc_core_tb.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the coprocessor core
module numc_core_tb;
    import numc_pkg::*;
    // Stimulus
    logic clk, sys_rst, board_switch_on, parity_error;
    logic nmi_mask_wr, nmi_mask_val, cmd_valid;
    numc_op_t cmd_op;
    logic [2:0] cmd_index;
    numc_ext_t cmd_data;
    logic [5:0] cmd_exc;
    logic [3:0] cmd_cc;
    logic [1:0] cmd_tag;
    logic [7:0] cmd_cycles;
    logic [15:0] cmd_opcode;
    logic [19:0] cmd_ins_addr, cmd_opnd_addr, ia_keep;
    logic qs_low, qs_high;
    logic [6:0] bus_status;
    // Observed outputs
    logic cmd_ready, busy, cop_irq, nmi_out, nmi_mask, rd_valid;
    logic [15:0] status_word, control_word, tag_word;
    logic [6:0] sig_bits, bus_status_seen;
    numc_ext_t rd_data;
    logic [19:0] operand_address_pointer, instruction_address_pointer;
    logic [10:0] captured_opcode;
    logic [7:0] stream_bytes;
    // Bookkeeping
    int errors, tests_run, busy_cnt;
    numc_ext_t rd_got;
    logic [6:0] sig_exp [4] = '{7'h18, 7'h00, 7'h35, 7'h40};
    localparam numc_ext_t VA = 80'h4001_8000_0000_0000_0003;
    localparam numc_ext_t VB = 80'hC002_A000_0000_0000_0000;

    // ==========================================
    // Design and host model
    numc_core u_dut (.clk, .sys_rst, .queue_status_low(qs_low),
        .queue_status_high(qs_high), .bus_status_lines(bus_status),
        .board_switch_on, .parity_error, .nmi_mask_wr, .nmi_mask_val,
        .cmd_valid, .cmd_op, .cmd_index, .cmd_data, .cmd_exc, .cmd_cc,
        .cmd_tag, .cmd_cycles, .cmd_opcode, .cmd_ins_addr,
        .cmd_opnd_addr, .cmd_ready, .busy, .cop_irq, .nmi_out, .nmi_mask,
        .status_word, .control_word, .tag_word, .sig_bits, .rd_data,
        .rd_valid, .operand_address_pointer, .captured_opcode,
        .instruction_address_pointer, .stream_bytes, .bus_status_seen);
    numc_host_model u_host (.clk, .qs_low, .qs_high, .bus_status);

    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ==========================================
    // Helpers
    task automatic chk(input logic [79:0] s, input logic [79:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("ERROR %0t: got %0h want %0h", $time, s, e);
        end
    endtask : chk
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Offer one instruction for a single edge
    task automatic offer(numc_op_t op, logic [7:0] cyc, numc_ext_t d);
        cmd_op = op;
        cmd_cycles = cyc;
        cmd_data = d;
        cmd_ins_addr = cmd_ins_addr + 20'h00013;
        cmd_opnd_addr = ~cmd_ins_addr;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
    endtask : offer
    // Execute and wait for not busy, counting busy cycles
    task automatic run(numc_op_t op, logic [7:0] cyc, numc_ext_t d);
        offer(op, cyc, d);
        busy_cnt = 0;
        while (busy === 1'b1 && busy_cnt < 300) begin
            chk({status_word[15], cmd_ready}, 2'h2);
            busy_cnt++;
            tick(1);
        end
        if (busy_cnt >= 300) begin
            errors++;
            $display("ERROR %0t: busy never dropped", $time);
            complete_run();
        end
        chk({status_word[15], cmd_ready}, 2'h1);
        rd_got = rd_valid ? rd_data : 'x;
        tick(1);
    endtask : run

    // ==========================================
    // Main sequence
    initial begin
        errors = 0;
        tests_run = 0;
        {sys_rst, board_switch_on, parity_error} = 3'h4;
        {nmi_mask_wr, nmi_mask_val, cmd_valid} = 3'h0;
        cmd_op = OP_PUSH;
        {cmd_index, cmd_data, cmd_exc} = 89'h0;
        {cmd_cc, cmd_tag, cmd_cycles} = 14'h0001;
        cmd_opcode = 16'hD9C0;
        cmd_ins_addr = 20'h10000;
        cmd_opnd_addr = 20'h2F00F;
        tick(5);
        sys_rst = 1'b0;
        chk(status_word, 16'h0000);
        chk(control_word, 16'h00BF);
        chk(tag_word, 16'hFFFF);
        chk({nmi_mask, nmi_out}, 2'h0);
        chk(sig_bits, 7'h18);
        $display("test reset done");
        // Push, read, pop and wrap around
        run(OP_PUSH, 8'h02, VA);
        chk(busy_cnt, 2);
        chk(status_word[13:11], 3'h7);
        chk(tag_word[15:14], 2'h0);
        chk(instruction_address_pointer, cmd_ins_addr);
        chk(operand_address_pointer, cmd_opnd_addr);
        chk(captured_opcode, cmd_opcode[10:0]);
        cmd_tag = 2'h1;
        run(OP_PUSH, 8'h01, VB);
        chk({status_word[13:11], tag_word[13:12]}, 5'h19);
        cmd_index = 3'h1;
        run(OP_READ, 8'h01, 80'h0);
        chk(rd_got, VA);
        run(OP_POP, 8'h01, 80'h0);
        chk(rd_got, VB);
        chk({status_word[13:11], tag_word[13:12]}, 5'h1F);
        run(OP_POP, 8'h01, 80'h0);
        chk({rd_got, status_word[13:11]}, {VA, 3'h0});
        run(OP_DECSTP, 8'h01, 80'h0);
        chk(status_word[13:11], 3'h7);
        run(OP_INCSTP, 8'h01, 80'h0);
        cmd_index = 3'h2;
        cmd_tag = 2'h2;
        run(OP_WRITE, 8'h01, VB);
        chk(tag_word[5:4], 2'h2);
        run(OP_READ, 8'h01, 80'h0);
        chk(rd_got, VB);
        $display("test stack done");
        // Precision, rounding and infinity fields
        for (int p = 0; p < 4; p++) begin
            run(OP_LDCW, 8'h01, {64'h0, 6'h16, p[1:0], 8'hFF});
            chk(control_word, {6'h06, p[1:0], 8'hBF});
            chk(sig_bits, sig_exp[p]);
        end
        run(OP_LDTW, 8'h01, 80'h5A3C);
        chk(tag_word, 16'h5A3C);
        $display("test control done");
        // Exception, request and host interrupt path
        run(OP_LDCW, 8'h01, 80'h0);
        {cmd_exc, cmd_cc} = 10'h04B;
        run(OP_CMP, 8'h01, 80'h0);
        cmd_exc = 6'h00;
        chk(status_word, 16'h4384);
        chk({cop_irq, nmi_out}, 2'h2);
        {nmi_mask_wr, nmi_mask_val} = 2'h3;
        tick(1);
        nmi_mask_wr = 1'b0;
        tick(2);
        chk({nmi_mask, nmi_out}, 2'h3);
        board_switch_on = 1'b1;
        tick(6);
        chk(nmi_out, 1'b0);
        board_switch_on = 1'b0;
        tick(6);
        chk(nmi_out, 1'b1);
        run(OP_DISI, 8'h01, 80'h0);
        chk({control_word[7], cop_irq}, 2'h2);
        tick(2);
        chk(nmi_out, 1'b0);
        run(OP_LDCW, 8'h01, 80'h3F);
        chk(status_word[7:0], 8'h04);
        parity_error = 1'b1;
        tick(6);
        chk(nmi_out, 1'b1);
        parity_error = 1'b0;
        tick(6);
        chk(nmi_out, 1'b0);
        run(OP_CLEX, 8'h01, 80'h0);
        chk(status_word[7:0], 8'h00);
        $display("test interrupt done");
        // Refused requests and clear during execution
        ia_keep = instruction_address_pointer;
        cmd_opcode = 16'h1234;
        offer(OP_PUSH, 8'h01, VA);
        tick(3);
        chk({busy, status_word[13:11]}, 4'h0);
        chk(instruction_address_pointer, ia_keep);
        cmd_opcode = 16'hDD29;
        offer(OP_PUSH, 8'h08, VA);
        tick(1);
        offer(OP_INCSTP, 8'h01, 80'h0);
        tick(1);
        run(OP_CLEX, 8'h01, 80'h0);
        chk(busy_cnt, 0);
        chk(status_word[13:11], 3'h0);
        chk(captured_opcode, 11'h529);
        $display("test refusal done");
        // Instruction stream tracking
        u_host.fetch(3, 7'h2C);
        chk(stream_bytes, 8'h03);
        chk(bus_status_seen, 7'h2C);
        u_host.flush();
        chk(stream_bytes, 8'h00);
        $display("test stream done");
        complete_run();
    end
endmodule : numc_core_tb
